// ---- logic/pwmsup_params.svh ----
// timing counts, limits and field positions of the pwm sync lock supervisor
`ifndef PWMSUP_PARAMS_SVH
`define PWMSUP_PARAMS_SVH

`define PWMSUP_CLK_NS          8
`define PWMSUP_CLK_KHZ         125000
`define PWMSUP_SYNC_MIN_KHZ    250
`define PWMSUP_STD_MAX_KHZ     1250
`define PWMSUP_HF_MAX_KHZ      2500
`define PWMSUP_VCO_MIN_KHZ     100
`define PWMSUP_EXT_TIMEOUT_NS  8000
`define PWMSUP_EXT_TIMEOUT_CYC (`PWMSUP_EXT_TIMEOUT_NS / `PWMSUP_CLK_NS)
`define PWMSUP_LOCK_PERIODS    3'd4
`define PWMSUP_PER_TOL         12'd2
`define PWMSUP_LOCK_BIT        4
`define PWMSUP_OV_HW_ONLY      8'h00
`define PWMSUP_PHASE_SHIFT     3
`define PWMSUP_FREQ_EXT_ONLY   16'h0000

`endif

// ---- logic/pwmsup_pkg.sv ----
// types of the pwm sync lock supervisor
package pwmsup_pkg;

  typedef enum logic [1:0] {
    PWMSUP_CH_OFF,
    PWMSUP_CH_RUN,
    PWMSUP_CH_OVF
  } pwmsup_ch_e_t;

  typedef struct packed {
    logic [2:0]  sh;
    logic [11:0] cnt;
    logic [11:0] per;
    logic        pres;
  } pwmsup_meas_t;

  typedef struct packed {
    logic [4:0]                pin_s1;
    logic [4:0]                pin_s2;
    logic [1:0]                init;
    logic                      strap_gnd;
    logic                      boot_hold;
    logic                      ext_src;
    logic [11:0]               base;
    logic [11:0]               last_p;
    logic [2:0]                lcnt;
    logic                      locked;
    logic                      lock_flt;
    logic                      alert_drv;
    logic                      sync_out;
    logic [1:0][11:0]          ch_cnt;
    logic [1:0]                ramp_lock;
    pwmsup_ch_e_t [1:0]        ch_st;
    logic [1:0]                pwm;
    logic [1:0]                ov_flt;
  } pwmsup_state_t;

endpackage : pwmsup_pkg

// ---- logic/pwmsup_sync_meas.sv ----
// sync pin synchroniser, falling edge finder and period meter
`include "pwmsup_params.svh"

module pwmsup_sync_meas (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        sync_i,
  output logic             fall_o,
  output logic [11:0]      period_o,
  output logic             present_o
);
  import pwmsup_pkg::*;

  localparam logic [11:0] TIMEOUT = 12'(`PWMSUP_EXT_TIMEOUT_CYC);

  pwmsup_meas_t q;
  pwmsup_meas_t d;
  logic         fall;

  always_comb begin
    d    = q;
    d.sh = {q.sh[1:0], sync_i};
    // only the falling edge defines timing
    fall = q.sh[2] & ~q.sh[1];
    if (fall) begin
      d.per  = q.cnt;
      d.cnt  = 12'h001;
      d.pres = 1'b1;
    end else begin
      if (q.cnt != 12'hfff) begin
        d.cnt = q.cnt + 12'h001;
      end
      if (q.cnt >= TIMEOUT) begin
        d.pres = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fall_o    = fall;
  assign period_o  = q.per;
  assign present_o = q.pres;

endmodule : pwmsup_sync_meas

// ---- logic/pwmsup_top.sv ----
// pwm sync lock supervisor: clock source selection, lock detect, channel gating
//
// Functional notes
// - lock both channels to external clock 250kHz..1.25MHz, 2.5MHz on fast variant.
// - loop follows falling edges of the sync pin only.
// - each channel phase offset follows its programmed phase selection.
// - lock loss in operation sets status bit 4 and pulls alert, unless masked.
// - host writes one to status bit 4 to clear the lock fault.
// - unlocked fault and alert may appear during start-up or reset.
// - no channel goes from off to run before lock.
// - entering run with unlocked channel ramp sets status bit 4.
// - without external clock, run at non-zero programmed switching frequency.
// - frequency zero or grounded strap: stay stopped after reset until external clock.
// - fast variant never runs the programmed frequency below 250kHz; external-only without clock still drops to 100kHz.
// - external-only with clock lost or absent under power: lowest oscillator frequency.
// - feedback strapped to internal supply makes a slave, error amplifier off.
// - slave seeing high shared compensation stops pwm, flags overvoltage, applies response.
// - with hardware-only response, slave resumes by itself when the fault clears.
`include "pwmsup_params.svh"

module pwmsup_top (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  sync_i,
  output logic                       sync_o,
  output logic                       sync_oe_n_o,
  input  wire logic                  sync_drive_en_i,
  input  wire logic                  hf_variant_i,
  input  wire logic [15:0]           freq_switch_i,
  input  wire logic                  frequency_strap_pin_i,
  input  wire logic                  vendor_reset_cmd_i,
  input  wire logic                  restore_user_i,
  input  wire logic [1:0][2:0]       phase_config_cmd_i,
  input  wire logic [1:0]            run_req_i,
  input  wire logic [1:0]            feedback_pin_strap_i,
  input  wire logic [1:0]            comp_high_i,
  input  wire logic [1:0][7:0]       ov_fault_response_i,
  input  wire logic [1:0]            ov_clr_i,
  input  wire logic                  lock_fault_mask_i,
  input  wire logic                  status_wr_i,
  input  wire logic [7:0]            status_wr_data_i,
  output logic [1:0]                 pwm_o,
  output logic [1:0]                 ch_run_o,
  output logic                       locked_o,
  output logic                       ext_clk_ok_o,
  output logic [7:0]                 vendor_status_byte_o,
  output logic                       alert_o,
  output logic                       alert_oe_n_o,
  output logic [1:0]                 ov_fault_o,
  output logic [1:0]                 err_amp_en_o
);
  import pwmsup_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic close_to(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] diff;
    diff = (a > b) ? (a - b) : (b - a);
    return diff <= `PWMSUP_PER_TOL;
  endfunction : close_to

  function automatic logic [11:0] period_of(input logic [15:0] khz);
    return 12'(32'(`PWMSUP_CLK_KHZ) / 32'(khz));
  endfunction : period_of

  // ----------------------------------------------------------------
  // sync pin measurement
  // ----------------------------------------------------------------
  logic        meas_fall;
  logic [11:0] meas_per;
  logic        meas_pres;

  pwmsup_sync_meas u_meas (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .sync_i     (sync_i),
    .fall_o     (meas_fall),
    .period_o   (meas_per),
    .present_o  (meas_pres)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  pwmsup_state_t q;
  pwmsup_state_t d;

  logic        rearm;
  logic        strap_eff;
  logic        ext_only;
  logic        ext_ok;
  logic [1:0]  slave;
  logic [1:0]  comp_hi;
  logic [15:0] max_khz;
  logic [15:0] fsw;
  logic [11:0] p;
  logic [11:0] half;
  logic        tick;
  logic [14:0] prod;
  logic [11:0] offs;

  always_comb begin
    d         = q;
    d.pin_s1  = {comp_high_i, feedback_pin_strap_i, frequency_strap_pin_i};
    d.pin_s2  = q.pin_s1;
    slave     = q.pin_s2[2:1];
    comp_hi   = q.pin_s2[4:3];
    prod      = '0;
    offs      = '0;

    // strap sampled once the pin chain has refilled after reset, and on reset commands
    rearm     = (q.init == 2'd2) | vendor_reset_cmd_i | restore_user_i;
    strap_eff = rearm ? q.pin_s2[0] : q.strap_gnd;
    if (q.init != 2'd3) begin
      d.init = q.init + 2'd1;
    end
    if (rearm) begin
      d.strap_gnd = q.pin_s2[0];
    end
    ext_only = strap_eff | (freq_switch_i == `PWMSUP_FREQ_EXT_ONLY);

    // clock source and period
    max_khz = hf_variant_i ? 16'(`PWMSUP_HF_MAX_KHZ) : 16'(`PWMSUP_STD_MAX_KHZ);
    ext_ok  = meas_pres && (meas_per >= period_of(max_khz))
              && (meas_per <= period_of(16'(`PWMSUP_SYNC_MIN_KHZ)));
    fsw = freq_switch_i;
    if (hf_variant_i && fsw < 16'(`PWMSUP_SYNC_MIN_KHZ)) begin
      fsw = 16'(`PWMSUP_SYNC_MIN_KHZ);
    end
    if (fsw > max_khz) begin
      fsw = max_khz;
    end
    if (fsw < 16'(`PWMSUP_VCO_MIN_KHZ)) begin
      fsw = 16'(`PWMSUP_VCO_MIN_KHZ);
    end
    if (ext_ok) begin
      p = meas_per;
    end else if (ext_only) begin
      p = period_of(16'(`PWMSUP_VCO_MIN_KHZ));
    end else begin
      p = period_of(fsw);
    end
    half     = p >> 1;
    d.ext_src = ext_ok;

    // hold after reset in external-only mode until a clock arrives
    if (ext_ok || !ext_only) begin
      d.boot_hold = 1'b0;
    end else if (rearm) begin
      d.boot_hold = 1'b1;
    end

    // base timing restarted by sync falling edge or free-running wrap
    tick   = ext_ok ? meas_fall : (q.base >= p - 12'h001);
    d.base = tick ? 12'h000 : ((q.base == 12'hfff) ? q.base : q.base + 12'h001);
    d.sync_out = (d.base >= half);

    // lock detect: several consecutive matching periods from one source
    if ((q.ext_src != ext_ok) || rearm) begin
      d.lcnt = '0;
    end else if (tick) begin
      d.last_p = p;
      if (close_to(p, q.last_p)) begin
        if (q.lcnt != `PWMSUP_LOCK_PERIODS) begin
          d.lcnt = q.lcnt + 3'd1;
        end
      end else begin
        d.lcnt = '0;
      end
    end
    d.locked = (d.lcnt == `PWMSUP_LOCK_PERIODS);

    // clear first so a simultaneous set wins
    if (status_wr_i && status_wr_data_i[`PWMSUP_LOCK_BIT]) begin
      d.lock_flt = 1'b0;
    end
    // no blanking at start-up: reset of the lock counter may report a fault
    if (q.locked && !d.locked && !lock_fault_mask_i) begin
      d.lock_flt = 1'b1;
    end

    // channel ramps and state
    for (int c = 0; c < 2; c++) begin
      prod = 15'(p) * 15'(phase_config_cmd_i[c]);
      offs = 12'(prod >> `PWMSUP_PHASE_SHIFT);
      if (q.base == offs) begin
        d.ramp_lock[c] = close_to(q.ch_cnt[c] + 12'h001, p);
        d.ch_cnt[c]    = 12'h000;
      end else if (q.ch_cnt[c] != 12'hfff) begin
        d.ch_cnt[c] = q.ch_cnt[c] + 12'h001;
      end
      if (ov_clr_i[c]) begin
        d.ov_flt[c] = 1'b0;
      end
      case (q.ch_st[c])
        PWMSUP_CH_OFF: begin
          if (run_req_i[c] && q.locked && !q.boot_hold) begin
            d.ch_st[c] = PWMSUP_CH_RUN;
            if (!q.ramp_lock[c] && !lock_fault_mask_i) begin
              d.lock_flt = 1'b1;
            end
          end
        end
        PWMSUP_CH_RUN: begin
          if (!run_req_i[c]) begin
            d.ch_st[c] = PWMSUP_CH_OFF;
          end else if (slave[c] && comp_hi[c]) begin
            d.ch_st[c] = PWMSUP_CH_OVF;
          end
        end
        PWMSUP_CH_OVF: begin
          if (!run_req_i[c]) begin
            d.ch_st[c] = PWMSUP_CH_OFF;
          end else if (!comp_hi[c]
                       && ov_fault_response_i[c] == `PWMSUP_OV_HW_ONLY) begin
            d.ch_st[c] = PWMSUP_CH_RUN;
          end
        end
        default: begin
          d.ch_st[c] = PWMSUP_CH_OFF;
        end
      endcase
      if (slave[c] && comp_hi[c] && q.ch_st[c] != PWMSUP_CH_OFF) begin
        d.ov_flt[c] = 1'b1;
      end
      // held pwm stays low even for channels already in run
      d.pwm[c] = (d.ch_st[c] == PWMSUP_CH_RUN) && !d.boot_hold
                 && (d.ch_cnt[c] < half);
    end

    d.alert_drv = d.lock_flt & ~lock_fault_mask_i;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sync_o               = q.sync_out;
  assign sync_oe_n_o          = ~sync_drive_en_i;
  assign pwm_o                = q.pwm;
  assign ch_run_o[0]          = (q.ch_st[0] == PWMSUP_CH_RUN);
  assign ch_run_o[1]          = (q.ch_st[1] == PWMSUP_CH_RUN);
  assign locked_o             = q.locked;
  assign ext_clk_ok_o         = q.ext_src;
  assign vendor_status_byte_o = {3'b000, q.lock_flt, 4'b0000};
  assign alert_o              = 1'b0;
  assign alert_oe_n_o         = ~q.alert_drv;
  assign ov_fault_o           = q.ov_flt;
  assign err_amp_en_o         = ~q.pin_s2[2:1];

endmodule : pwmsup_top

// ---- tb/pwmsup_sync_src.sv ----
// clock source model on the shared sync pin
module pwmsup_sync_src (
  input  wire logic        run_i,
  input  wire logic        skew_i,
  input  wire logic [15:0] per_ns_i,
  output logic             sync_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic alt = 1'b0;

  // idles high between bursts; skew moves only the rising edges
  initial begin
    sync_o = 1'b1;
    forever begin
      wait (run_i);
      sync_o = 1'b0;
      #(per_ns_i * (skew_i ? (alt ? 0.3 : 0.7) : 0.5));
      sync_o = 1'b1;
      alt = !alt;
      #(per_ns_i * (skew_i ? (alt ? 0.3 : 0.7) : 0.5));
    end
  end
endmodule : pwmsup_sync_src

// ---- tb/pwmsup_top_monitor.sv ----
// port assertions of the pwm sync lock supervisor
module pwmsup_top_monitor (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       sync_drive_en_i,
  input wire logic       sync_oe_n_o,
  input wire logic [1:0] run_req_i,
  input wire logic [1:0] feedback_pin_strap_i,
  input wire logic [1:0] comp_high_i,
  input wire logic       lock_fault_mask_i,
  input wire logic       status_wr_i,
  input wire logic [7:0] status_wr_data_i,
  input wire logic       vendor_reset_cmd_i,
  input wire logic       restore_user_i,
  input wire logic [1:0] pwm_o,
  input wire logic [1:0] ch_run_o,
  input wire logic       locked_o,
  input wire logic [7:0] vendor_status_byte_o,
  input wire logic       alert_oe_n_o,
  input wire logic [1:0] ov_fault_o,
  input wire logic [1:0] err_amp_en_o
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_sync_drive_sel: assert property (sync_oe_n_o == !sync_drive_en_i)
    else $error("sync enable wrong");
  a_run_after_lock: assert property ($rose(ch_run_o[0]) || $rose(ch_run_o[1]) |->
    $past(locked_o)) else $error("run without lock");
  a_loss_sets_flag: assert property ($fell(locked_o) && !lock_fault_mask_i |->
    ##[0:1] (vendor_status_byte_o[4] && !alert_oe_n_o)) else $error("lock loss unflagged");
  a_flag_write_clr: assert property (status_wr_i && status_wr_data_i[4] && locked_o &&
    $stable(run_req_i) |=> !vendor_status_byte_o[4] || !locked_o) else $error("no clear");
  a_flag_stays_set: assert property (vendor_status_byte_o[4] && !vendor_reset_cmd_i &&
    !restore_user_i && !(status_wr_i && status_wr_data_i[4]) |=> vendor_status_byte_o[4])
    else $error("flag dropped");
  a_status_spare_zero: assert property ({vendor_status_byte_o[7:5],
    vendor_status_byte_o[3:0]} == 7'h00) else $error("spare status bit set");
  a_slave_amp_off: assert property (feedback_pin_strap_i[1] [*4] |=>
    !err_amp_en_o[1]) else $error("slave amp on");
  a_slave_ov_stop: assert property (ch_run_o[1] && feedback_pin_strap_i[1] &&
    comp_high_i[1] |-> ##[1:4] (ov_fault_o[1] && !pwm_o[1])) else $error("slave not stopped");
endmodule : pwmsup_top_monitor

// ---- tb/tb_pwm_sync_lock_supervisor.sv ----
// self-checking bench of the pwm sync lock supervisor
module tb_pwm_sync_lock_supervisor;
  timeunit 1ns;
  timeprecision 100ps;

  logic             core_clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             sync_i;
  logic             sync_o, sync_oe_n_o, locked_o, ext_clk_ok_o, alert_o, alert_oe_n_o;
  logic [1:0]       pwm_o, ch_run_o, ov_fault_o, err_amp_en_o, pwm_prev;
  logic [7:0]       vendor_status_byte_o;
  logic             sync_drive_en_i = 1'b0, hf_variant_i = 1'b0, lock_fault_mask_i = 1'b0;
  logic             frequency_strap_pin_i = 1'b0, vendor_reset_cmd_i = 1'b0;
  logic             restore_user_i = 1'b0, status_wr_i = 1'b0;
  logic [15:0]      freq_switch_i = 16'h01f4;
  logic [1:0][2:0]  phase_config_cmd_i = {3'h4, 3'h0};
  logic [1:0]       run_req_i = 2'h0, comp_high_i = 2'h0, ov_clr_i = 2'h0;
  logic [1:0]       feedback_pin_strap_i = 2'h2;
  logic [1:0][7:0]  ov_fault_response_i = 16'h0000;
  logic [7:0]       status_wr_data_i = 8'h00;
  logic             src_run = 1'b0, src_skew = 1'b1, src_sync;
  logic [15:0]      src_per = 16'h007d;
  int               miscompares = 0;
  int               checks_done = 0;

  assign sync_i = sync_oe_n_o ? src_sync : sync_o;

  pwmsup_top dut (.*);
  pwmsup_sync_src src (.run_i(src_run), .skew_i(src_skew), .per_ns_i(src_per), .sync_o(src_sync));

  initial forever #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) pwm_prev <= pwm_o;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic near(string what, int exp, int got);
    checks_done++;
    if (got > exp + 2 || got < exp - 2) begin
      miscompares++;
      $display("BAD %s exp %0d got %0d", what, exp, got);
    end
  endtask : near

  task automatic cyc(int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  // cycles from a rise of pwm a to the next rise of pwm b
  task automatic gap_chk(string what, int a, int b, int exp);
    int n;
    for (n = 0; n < 3000 && !(pwm_o[a] && !pwm_prev[a]); n++) @(negedge core_clk_i);
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (n < 3000 && !(pwm_o[b] && !pwm_prev[b]));
    near(what, exp, n);
  endtask : gap_chk

  task automatic clr_flag;
    @(posedge core_clk_i);
    status_wr_i <= 1'b1;
    status_wr_data_i <= 8'h10;
    @(posedge core_clk_i);
    status_wr_i <= 1'b0;
    @(negedge core_clk_i);
  endtask : clr_flag

  task automatic finish_test;
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_free_run;
    @(posedge core_clk_i);
    run_req_i <= 2'b11;
    for (int i = 0; i < 3000 && locked_o !== 1'b1; i++) @(negedge core_clk_i);
    cyc(2);
    chk("locked", 1'b1, locked_o);
    chk("run", 2'b11, ch_run_o);
    chk("ext ok", 1'b0, ext_clk_ok_o);
    chk("amp en", 2'b01, err_amp_en_o);
    gap_chk("free period", 0, 0, 250);
    chk("sync low", 1'b0, sync_o);
    cyc(125);
    chk("sync high", 1'b1, sync_o);
    gap_chk("phase", 0, 1, 125);
  endtask : t_free_run

  task automatic t_ext;
    src_run = 1'b1;
    cyc(1200);
    chk("fast refused", 1'b0, ext_clk_ok_o);
    src_per = 16'd1000;
    cyc(1500);
    chk("ext used", 1'b1, ext_clk_ok_o);
    chk("ext lock", 1'b1, locked_o);
    gap_chk("ext period", 0, 0, 125);
  endtask : t_ext

  task automatic t_loss;
    clr_flag;
    chk("flag clr", 1'b0, vendor_status_byte_o[4]);
    src_per = 16'd2000;
    cyc(800);
    chk("loss flag", 1'b1, vendor_status_byte_o[4]);
    chk("alert", 1'b0, alert_oe_n_o);
    chk("alert lvl", 1'b0, alert_o);
    cyc(2500);
    chk("relock", 1'b1, locked_o);
    chk("sticky", 1'b1, vendor_status_byte_o[4]);
    clr_flag;
    chk("flag clr2", 1'b0, vendor_status_byte_o[4]);
    chk("alert off", 1'b1, alert_oe_n_o);
  endtask : t_loss

  task automatic t_slave;
    @(posedge core_clk_i);
    comp_high_i <= 2'b10;
    cyc(6);
    chk("ov flag", 2'b10, ov_fault_o);
    chk("slave stop", 2'b01, ch_run_o);
    chk("slave pwm", 1'b0, pwm_o[1]);
    @(posedge core_clk_i);
    comp_high_i <= 2'b00;
    cyc(6);
    chk("resume", 2'b11, ch_run_o);
    @(posedge core_clk_i);
    ov_clr_i <= 2'b10;
    @(posedge core_clk_i);
    ov_clr_i <= 2'b00;
    cyc(1);
    chk("ov clr", 2'b00, ov_fault_o);
    @(posedge core_clk_i);
    ov_fault_response_i <= 16'h8000;
    comp_high_i <= 2'b10;
    cyc(6);
    @(posedge core_clk_i);
    comp_high_i <= 2'b00;
    cyc(6);
    chk("latched off", 2'b01, ch_run_o);
    @(posedge core_clk_i);
    run_req_i <= 2'b01;
    ov_fault_response_i <= 16'h0000;
    @(posedge core_clk_i);
    run_req_i <= 2'b11;
    cyc(2);
    chk("rerun", 2'b11, ch_run_o);
  endtask : t_slave

  task automatic t_ext_only;
    src_run = 1'b0;
    src_per = 16'd1000;
    cyc(1500);
    @(posedge core_clk_i);
    freq_switch_i <= 16'h0000;
    restore_user_i <= 1'b1;
    @(posedge core_clk_i);
    restore_user_i <= 1'b0;
    cyc(1500);
    chk("held pwm", 2'b00, pwm_o);
    src_run = 1'b1;
    cyc(1500);
    chk("ext start", 2'b11, ch_run_o);
    chk("ext back", 1'b1, ext_clk_ok_o);
    gap_chk("ext run", 0, 0, 125);
    src_run = 1'b0;
    cyc(2500);
    gap_chk("vco floor", 0, 0, 1250);
  endtask : t_ext_only

  task automatic t_hf;
    @(posedge core_clk_i);
    hf_variant_i <= 1'b1;
    freq_switch_i <= 16'h0064;
    cyc(3000);
    gap_chk("hf floor", 0, 0, 500);
  endtask : t_hf

  task automatic t_strap;
    @(posedge core_clk_i);
    frequency_strap_pin_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    vendor_reset_cmd_i <= 1'b1;
    @(posedge core_clk_i);
    vendor_reset_cmd_i <= 1'b0;
    cyc(1500);
    chk("strap hold", 2'b00, pwm_o);
    @(posedge core_clk_i);
    frequency_strap_pin_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    vendor_reset_cmd_i <= 1'b1;
    @(posedge core_clk_i);
    vendor_reset_cmd_i <= 1'b0;
    cyc(1);
    gap_chk("strap free", 0, 0, 500);
  endtask : t_strap

  initial begin
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_free_run;
    t_ext;
    t_loss;
    t_slave;
    t_ext_only;
    t_hf;
    t_strap;
    finish_test;
  end

  initial begin
    repeat (60000) @(posedge core_clk_i);
    miscompares++;
    finish_test;
  end
endmodule : tb_pwm_sync_lock_supervisor

bind pwmsup_top pwmsup_top_monitor u_mon (.*);
